// File: dpr_regs.svh
// register map, field positions, reset values and fixed ratios of the restraint block
//
// Overview of operation
// - restraint sums magnitudes; differential is phasor-sum magnitude
// - trip needs differential above base pickup
// - high early restraint in add-on region: external
// - saturation decision within first quarter cycle
// - external fault blocks differential trip for set time
// - one stationary cycle near fault line cancels block
// - per-phase add-on restraint; option blocks all phases
// - DC component doubles first characteristic branch
// - second harmonic above threshold blocks threshold stage
// - extra blocking harmonic: third or fifth selectable
// - enabled asymmetry detector blocks threshold stage
// - filtered harmonic content per phase starts restraint
// - per-phase harmonic blocking; optional crossblock all phases
// - crossblock limited to settable maximum duration
// - unrestrained stage ignores restraint and harmonic blocking
// - unrestrained uses fundamental and instantaneous values
// - instantaneous part needs two root two threshold
`ifndef DPR_REGS_SVH
`define DPR_REGS_SVH

`define DPR_NPH 3
`define DPR_MAG_W 20
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define DPR_OFF_CTRL 8'h00
`define DPR_OFF_PICKUP 8'h04
`define DPR_OFF_SLOPE 8'h08
`define DPR_OFF_ADDON 8'h0C
`define DPR_OFF_EXTTIME 8'h10
`define DPR_OFF_H2PCT 8'h14
`define DPR_OFF_HNPCT 8'h18
`define DPR_OFF_XTIME 8'h1C
`define DPR_OFF_HITHR 8'h20
`define DPR_OFF_DCTHR 8'h24
`define DPR_OFF_STATUS 8'h28
// ----------------------------------------------------------------
// control bits
// ----------------------------------------------------------------
`define DPR_CTL_EN 0
`define DPR_CTL_BLKALL 1
`define DPR_CTL_XBLK 2
`define DPR_CTL_HNEN 3
`define DPR_CTL_HNSEL 4
`define DPR_CTL_CWAEN 5
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define DPR_RST_CTRL 6'h01
`define DPR_RST_PICKUP 16'h0100
`define DPR_RST_SLOPE 8'h40
`define DPR_RST_ADDON 16'h1000
`define DPR_RST_EXTTIME 16'h0064
`define DPR_RST_H2PCT 8'h0F
`define DPR_RST_HNPCT 8'h1E
`define DPR_RST_XTIME 16'h0028
`define DPR_RST_HITHR 16'h2000
`define DPR_RST_DCTHR 16'h0080
// ----------------------------------------------------------------
// fixed ratios: 80 % = 4/5, 2*sqrt2 ~ 181/64, slope in 1/256
// ----------------------------------------------------------------
`define DPR_NEAR_NUM 32'h4
`define DPR_NEAR_DEN 32'h5
`define DPR_RT2_NUM 32'hB5
`define DPR_RT2_SHF 6
`define DPR_SLOPE_SHF 8
`define DPR_PCT 32'h64
`define DPR_DC_SHF 1

`endif

// File: dpr_pkg.sv
// types shared by the restraint block modules
package dpr_pkg;
  // one complex quantity from the filter front-end
  typedef struct packed {
    logic signed [15:0] re; // real part
    logic signed [15:0] im; // imaginary part
  } dpr_phasor_t;

  // saturation detector state of one phase
  typedef struct packed {
    logic prevIdle; // restraint was below pickup last sample
    logic [7:0] winCnt; // samples left in decision window
    logic [15:0] blkCnt; // samples of blocking left
    logic [7:0] statCnt; // stationary samples near fault line
    logic extFault; // external fault declared
  } dpr_sat_st_t;

  // whole state of the main module
  typedef struct packed {
    logic [5:0] ctrl;
    logic [15:0] pickup;
    logic [7:0] slope;
    logic [15:0] addOn;
    logic [15:0] extTime;
    logic [7:0] h2Pct;
    logic [7:0] hnPct;
    logic [15:0] xTime;
    logic [15:0] hiThr;
    logic [15:0] dcThr;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [2:0] extBlk;
    logic [2:0] harmBlk;
    logic [15:0] xCnt;
    logic xAct;
    logic [2:0] unrTrip;
    logic [2:0] trip;
  } dpr_main_st_t;
endpackage : dpr_pkg

// File: dpr_sat_det.sv
// per-phase CT saturation indicator with timed external-fault blocking
`timescale 1ns/1ns
`default_nettype none
`include "dpr_regs.svh"
module dpr_sat_det #(
  parameter int SPC = 20 // samples per power-system cycle
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic sampleStb, // one pulse per sample
  input wire logic [`DPR_MAG_W-1:0] restMag, // restraint quantity
  input wire logic [15:0] pickup, // base pickup
  input wire logic [15:0] addOn, // add-on region restraint threshold
  input wire logic [15:0] extTime, // blocking time in samples
  input wire logic tripZone, // operating point in trip area
  input wire logic nearFault, // at or above 80 % of fault slope
  output logic extFault // external fault blocking active
);
  localparam logic [7:0] QTR = 8'(SPC / 4); // quarter cycle, at least one sample
  localparam logic [7:0] QWIN = (QTR == 8'h00) ? 8'h01 : QTR;
  localparam logic [7:0] CYC = 8'(SPC);
  localparam logic [7:0] QREM = QWIN - 8'h01; // window samples after the inception sample

  dpr_pkg::dpr_sat_st_t st_reg; // registered state
  dpr_pkg::dpr_sat_st_t st_next; // next state
  logic idle; // no fault current present
  logic inAddOn; // high restraint, differential well below fault line
  logic inWin; // inception sample or open decision window

  assign idle = restMag < {4'h0, pickup};
  assign inAddOn = (restMag >= {4'h0, addOn}) && !nearFault;
  assign inWin = (st_reg.winCnt != 8'h00) || (st_reg.prevIdle && !idle);
  assign extFault = st_reg.extFault;

  // ----------------------------------------------------------------
  // detector state update
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    if (sampleStb)
    begin
      st_next.prevIdle = idle;
      // the inception sample is the first of the quarter-cycle window
      if (st_reg.prevIdle && !idle)
        st_next.winCnt = QREM;
      else if (st_reg.winCnt != 8'h00)
        st_next.winCnt = st_reg.winCnt - 8'h01;
      if (st_reg.extFault)
      begin
        // a stationary cycle near the fault line lifts blocking early
        if (tripZone && nearFault)
          st_next.statCnt = st_reg.statCnt + 8'h01;
        else
          st_next.statCnt = 8'h00;
        if (tripZone && nearFault && (st_reg.statCnt + 8'h01 >= CYC))
          st_next.extFault = 1'b0;
        else if (st_reg.blkCnt == 16'h0000)
          st_next.extFault = 1'b0;
        else
          st_next.blkCnt = st_reg.blkCnt - 16'h0001;
      end
      // deciding on the inception sample already puts the block ahead of saturation
      if (inWin && inAddOn)
      begin
        st_next.extFault = 1'b1;
        st_next.blkCnt = extTime;
        st_next.statCnt = 8'h00;
      end
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      st_reg <= '{prevIdle: 1'b1, winCnt: 8'h00, blkCnt: 16'h0000,
                  statCnt: 8'h00, extFault: 1'b0};
    else
      st_reg <= st_next;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_sat_decision: assert property (sampleStb && inWin && inAddOn
    |=> extFault) else $error("add-on point in window did not declare external fault");
  a_window_quarter: assert property (sampleStb && st_reg.prevIdle && !idle
    |=> st_reg.winCnt == QREM) else $error("decision window not opened for a quarter cycle");
  a_block_holds: assert property (sampleStb && extFault && st_reg.blkCnt != 16'h0000
    && !(tripZone && nearFault) |=> extFault) else $error("external blocking ended early");
endmodule : dpr_sat_det
`default_nettype wire

// File: dpr_restraint.sv
// differential restraint, blocking and unrestrained trip logic with APB registers
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "dpr_regs.svh"
module dpr_restraint #(
  parameter int NLOC = 2, // measuring locations per phase
  parameter int SPC = 20 // samples per power-system cycle
) (
  input wire logic clk_sys, // 50 MHz system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB write
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic sampleStb, // one pulse per new sample set
  input wire dpr_pkg::dpr_phasor_t fundPh [`DPR_NPH][NLOC], // fundamental phasors
  input wire dpr_pkg::dpr_phasor_t h2Ph [`DPR_NPH][NLOC], // second harmonic phasors
  input wire dpr_pkg::dpr_phasor_t h3Ph [`DPR_NPH][NLOC], // third harmonic phasors
  input wire dpr_pkg::dpr_phasor_t h5Ph [`DPR_NPH][NLOC], // fifth harmonic phasors
  input wire logic signed [15:0] dcVal [`DPR_NPH][NLOC], // DC component per location
  input wire logic signed [15:0] instVal [`DPR_NPH][NLOC], // instantaneous samples
  input wire logic [`DPR_NPH-1:0] asymDet, // waveform_asymmetry_detector result
  output logic [`DPR_NPH-1:0] trip, // per-phase trip
  output logic [`DPR_NPH-1:0] extBlock, // external-fault blocking status
  output logic [`DPR_NPH-1:0] harmBlock, // harmonic blocking status
  output logic crossActive, // crossblock in force
  output logic [`DPR_NPH-1:0] unrTrip // unrestrained stage trip
);
  localparam int MW = `DPR_MAG_W;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // magnitude estimate: max + 3/8 min, good to a few percent
  function automatic logic [MW-1:0] magEst(input logic signed [MW-1:0] re,
                                            input logic signed [MW-1:0] im);
    logic [MW-1:0] a;
    logic [MW-1:0] b;
    logic [MW-1:0] hi;
    logic [MW-1:0] lo;
    a = re[MW-1] ? MW'(-re) : MW'(re);
    b = im[MW-1] ? MW'(-im) : MW'(im);
    hi = (a > b) ? a : b;
    lo = (a > b) ? b : a;
    magEst = hi + MW'((lo * MW'(3)) >> 3);
  endfunction : magEst

  dpr_pkg::dpr_main_st_t st_reg; // registered state
  dpr_pkg::dpr_main_st_t st_next; // next state

  logic [MW-1:0] diffMag [`DPR_NPH]; // differential_current
  logic [MW-1:0] restMag [`DPR_NPH]; // restraint_current
  logic [MW-1:0] h2Mag [`DPR_NPH]; // second harmonic of differential
  logic [MW-1:0] hnMag [`DPR_NPH]; // selected extra harmonic
  logic [MW-1:0] dcMag [`DPR_NPH]; // DC in differential
  logic [MW-1:0] instAbs [`DPR_NPH]; // instantaneous differential, absolute
  logic [`DPR_NPH-1:0] tripZone; // point above characteristic
  logic [`DPR_NPH-1:0] nearFault; // at or above 80 % of fault slope
  logic [`DPR_NPH-1:0] harmRaw; // per-phase harmonic or asymmetry block
  logic [`DPR_NPH-1:0] unrNow; // unrestrained condition
  logic [`DPR_NPH-1:0] extRaw; // saturation detector outputs
  logic [`DPR_NPH-1:0] extEff; // external blocking after phase option
  logic [`DPR_NPH-1:0] harmEff; // harmonic blocking after crossblock
  logic xNow; // crossblock applies this sample
  logic enable; // protection enabled

  assign enable = st_reg.ctrl[`DPR_CTL_EN];

  // ----------------------------------------------------------------
  // per-phase measurands and criteria
  // ----------------------------------------------------------------
  for (genvar p = 0; p < `DPR_NPH; p++)
  begin : g_ph
    logic signed [MW-1:0] sRe; // phasor sum, fundamental
    logic signed [MW-1:0] sIm;
    logic signed [MW-1:0] s2Re; // phasor sum, second harmonic
    logic signed [MW-1:0] s2Im;
    logic signed [MW-1:0] snRe; // phasor sum, selected harmonic
    logic signed [MW-1:0] snIm;
    logic signed [MW-1:0] sDc; // DC sum
    logic signed [MW-1:0] sInst; // instantaneous sum
    logic [MW-1:0] sMag; // sum of magnitudes
    logic [31:0] pickEff; // first branch, doubled on DC

    // sums over measuring locations
    always_comb
    begin
      sRe = '0;
      sIm = '0;
      s2Re = '0;
      s2Im = '0;
      snRe = '0;
      snIm = '0;
      sDc = '0;
      sInst = '0;
      sMag = '0;
      for (int l = 0; l < NLOC; l++)
      begin
        sRe = sRe + MW'(fundPh[p][l].re);
        sIm = sIm + MW'(fundPh[p][l].im);
        s2Re = s2Re + MW'(h2Ph[p][l].re);
        s2Im = s2Im + MW'(h2Ph[p][l].im);
        // extra harmonic: fifth when selected, otherwise third
        snRe = snRe + MW'(st_reg.ctrl[`DPR_CTL_HNSEL] ? h5Ph[p][l].re : h3Ph[p][l].re);
        snIm = snIm + MW'(st_reg.ctrl[`DPR_CTL_HNSEL] ? h5Ph[p][l].im : h3Ph[p][l].im);
        sDc = sDc + MW'(dcVal[p][l]);
        sInst = sInst + MW'(instVal[p][l]);
        sMag = sMag + magEst(MW'(fundPh[p][l].re), MW'(fundPh[p][l].im));
      end
    end

    assign restMag[p] = sMag;
    assign diffMag[p] = magEst(sRe, sIm);
    assign h2Mag[p] = magEst(s2Re, s2Im);
    assign hnMag[p] = magEst(snRe, snIm);
    assign dcMag[p] = sDc[MW-1] ? MW'(-sDc) : MW'(sDc);
    assign instAbs[p] = sInst[MW-1] ? MW'(-sInst) : MW'(sInst);
    // DC in the differential above dcThr doubles the base branch while it stays above
    assign pickEff = (dcMag[p] > MW'(st_reg.dcThr)) ?
                     (32'(st_reg.pickup) << `DPR_DC_SHF) : 32'(st_reg.pickup);
    // base pickup and the proportional branch both must be exceeded
    assign tripZone[p] = (32'(diffMag[p]) > pickEff) &&
      ((32'(diffMag[p]) << `DPR_SLOPE_SHF) > 32'(st_reg.slope) * 32'(restMag[p]));
    assign nearFault[p] = 32'(diffMag[p]) * `DPR_NEAR_DEN >= 32'(restMag[p]) * `DPR_NEAR_NUM;
    // harmonic content in percent of the fundamental differential
    assign harmRaw[p] =
      (32'(h2Mag[p]) * `DPR_PCT > 32'(st_reg.h2Pct) * 32'(diffMag[p])) ||
      (st_reg.ctrl[`DPR_CTL_HNEN] &&
       (32'(hnMag[p]) * `DPR_PCT > 32'(st_reg.hnPct) * 32'(diffMag[p]))) ||
      (st_reg.ctrl[`DPR_CTL_CWAEN] && asymDet[p]);
    // fundamental over setting, or instantaneous value over 2*sqrt2 times setting
    assign unrNow[p] = enable && ((diffMag[p] > MW'(st_reg.hiThr)) ||
      ((32'(instAbs[p]) << `DPR_RT2_SHF) > 32'(st_reg.hiThr) * `DPR_RT2_NUM));

    dpr_sat_det #(
      .SPC(SPC)
    ) u_sat (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .sampleStb(sampleStb),
      .restMag(restMag[p]),
      .pickup(st_reg.pickup),
      .addOn(st_reg.addOn),
      .extTime(st_reg.extTime),
      .tripZone(tripZone[p]),
      .nearFault(nearFault[p]),
      .extFault(extRaw[p])
    );
  end

  // blocking scope: only the faulted phase or every phase
  assign extEff = st_reg.ctrl[`DPR_CTL_BLKALL] ? {`DPR_NPH{|extRaw}} : extRaw;
  // crossblock while any phase restrains, until its time runs out
  assign xNow = st_reg.ctrl[`DPR_CTL_XBLK] && (|harmRaw) && (st_reg.xCnt < st_reg.xTime);
  assign harmEff = xNow ? {`DPR_NPH{1'b1}} : harmRaw;

  // ----------------------------------------------------------------
  // next state: APB slave and protection outputs
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    // zero-wait slave: ready rises in the access phase only
    st_next.pready = psel && !penable && !st_reg.pready;
    if (psel && !penable)
    begin
      st_next.pslverr = 1'b0;
      st_next.prdata = 32'h0000_0000;
      unique case (paddr)
        `DPR_OFF_CTRL: st_next.prdata = 32'(st_reg.ctrl);
        `DPR_OFF_PICKUP: st_next.prdata = 32'(st_reg.pickup);
        `DPR_OFF_SLOPE: st_next.prdata = 32'(st_reg.slope);
        `DPR_OFF_ADDON: st_next.prdata = 32'(st_reg.addOn);
        `DPR_OFF_EXTTIME: st_next.prdata = 32'(st_reg.extTime);
        `DPR_OFF_H2PCT: st_next.prdata = 32'(st_reg.h2Pct);
        `DPR_OFF_HNPCT: st_next.prdata = 32'(st_reg.hnPct);
        `DPR_OFF_XTIME: st_next.prdata = 32'(st_reg.xTime);
        `DPR_OFF_HITHR: st_next.prdata = 32'(st_reg.hiThr);
        `DPR_OFF_DCTHR: st_next.prdata = 32'(st_reg.dcThr);
        // status is read-only; writes to it are silently dropped
        `DPR_OFF_STATUS: st_next.prdata = 32'({st_reg.trip, st_reg.unrTrip, st_reg.xAct,
                                               st_reg.harmBlk, st_reg.extBlk});
        default: st_next.pslverr = 1'b1; // unmapped address
      endcase
    end
    // writes land at the edge where ready is seen
    if (psel && penable && st_reg.pready && pwrite)
    begin
      unique case (paddr)
        `DPR_OFF_CTRL: st_next.ctrl = pwdata[5:0];
        `DPR_OFF_PICKUP: st_next.pickup = pwdata[15:0];
        `DPR_OFF_SLOPE: st_next.slope = pwdata[7:0];
        `DPR_OFF_ADDON: st_next.addOn = pwdata[15:0];
        `DPR_OFF_EXTTIME: st_next.extTime = pwdata[15:0];
        `DPR_OFF_H2PCT: st_next.h2Pct = pwdata[7:0];
        `DPR_OFF_HNPCT: st_next.hnPct = pwdata[7:0];
        `DPR_OFF_XTIME: st_next.xTime = pwdata[15:0];
        `DPR_OFF_HITHR: st_next.hiThr = pwdata[15:0];
        `DPR_OFF_DCTHR: st_next.dcThr = pwdata[15:0];
        default: st_next.ctrl = st_reg.ctrl;
      endcase
    end
    // protection decisions, once per sample
    if (sampleStb)
    begin
      // crossblock timer restarts whenever no phase restrains
      if (!(|harmRaw))
        st_next.xCnt = 16'h0000;
      else if (st_reg.xCnt != 16'hFFFF)
        st_next.xCnt = st_reg.xCnt + 16'h0001;
      st_next.xAct = xNow;
      st_next.extBlk = extEff;
      st_next.harmBlk = harmEff;
      st_next.unrTrip = unrNow;
      // unrestrained stage bypasses every restraint and block
      st_next.trip = unrNow |
        ({`DPR_NPH{enable}} & tripZone & ~extEff & ~harmEff);
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      st_reg <= '0;
      st_reg.ctrl <= `DPR_RST_CTRL;
      st_reg.pickup <= `DPR_RST_PICKUP;
      st_reg.slope <= `DPR_RST_SLOPE;
      st_reg.addOn <= `DPR_RST_ADDON;
      st_reg.extTime <= `DPR_RST_EXTTIME;
      st_reg.h2Pct <= `DPR_RST_H2PCT;
      st_reg.hnPct <= `DPR_RST_HNPCT;
      st_reg.xTime <= `DPR_RST_XTIME;
      st_reg.hiThr <= `DPR_RST_HITHR;
      st_reg.dcThr <= `DPR_RST_DCTHR;
    end
    else
      st_reg <= st_next;
  end

  // outputs straight from the state flops
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  assign trip = st_reg.trip;
  assign extBlock = st_reg.extBlk;
  assign harmBlock = st_reg.harmBlk;
  assign crossActive = st_reg.xAct;
  assign unrTrip = st_reg.unrTrip;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  a_unr_overrides: assert property (sampleStb && enable && diffMag[0] > MW'(st_reg.hiThr)
    |=> trip[0] && unrTrip[0]) else $error("unrestrained trip missing");
  a_inst_margin: assert property (sampleStb && diffMag[0] <= MW'(st_reg.hiThr) &&
    (32'(instAbs[0]) << `DPR_RT2_SHF) <= 32'(st_reg.hiThr) * `DPR_RT2_NUM |=> !unrTrip[0])
    else $error("instantaneous stage below its margin");
  a_harm_blocks: assert property (sampleStb && harmEff[0] && !unrNow[0]
    |=> !trip[0]) else $error("trip despite harmonic blocking");
  a_ext_blocks: assert property (sampleStb && extEff[0] && !unrNow[0]
    |=> !trip[0]) else $error("trip despite external fault blocking");
  a_base_pickup: assert property (sampleStb && diffMag[0] <= MW'(st_reg.pickup) &&
    !unrNow[0] |=> !trip[0]) else $error("trip below base pickup");
  a_dc_doubles: assert property (sampleStb && dcMag[0] > MW'(st_reg.dcThr) &&
    32'(diffMag[0]) <= (32'(st_reg.pickup) << `DPR_DC_SHF) && !unrNow[0] |=> !trip[0])
    else $error("DC doubling of first branch missing");
  a_cross_all: assert property (sampleStb && xNow
    |=> harmBlock == {`DPR_NPH{1'b1}} && crossActive) else $error("crossblock not on all phases");
  a_apb_ready: assert property (psel && !penable // apb
    |=> pready ##1 !pready) else $error("ready not a single access-phase cycle");
endmodule : dpr_restraint
`default_nettype wire

// File: dpr_frontend_model.sv
// front-end model: per-phase sampled phasors with a strobe every fourth cycle
`timescale 1ns/1ns
`default_nettype none
module dpr_frontend_model #(
  parameter int NLOC = 2 // measuring locations per phase
) (
  input wire logic clk_sys, // system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic [2:0] phMask, // phases that carry the test currents
  input wire logic signed [15:0] cur [4], // loc0, loc1, loc0 second harmonic, instantaneous
  output logic sampleStb, // one-cycle strobe per sample set
  output dpr_pkg::dpr_phasor_t fundPh [3][NLOC], // fundamental phasors, real axis only
  output dpr_pkg::dpr_phasor_t h2Ph [3][NLOC], // second harmonic, phase 0 location 0 only
  output logic signed [15:0] instVal [3][NLOC] // instantaneous samples
);
  logic [1:0] div; // strobe divider, a sample every fourth clock
  // strobe generator, silent in reset
  always_ff @(posedge clk_sys)
  begin
    div <= rst_b ? div + 2'h1 : 2'h0;
    sampleStb <= rst_b && (div == 2'h3);
  end
  // outside the strobe the lines carry inverted data, so stale samples can never pass
  always_comb
    for (int p = 0; p < 3; p++)
      for (int l = 0; l < NLOC; l++)
      begin
        fundPh[p][l] = {(phMask[p] && l < 2) ? cur[l] : 16'h0000, 16'h0000} ^ {32{!sampleStb}};
        h2Ph[p][l] = {(phMask[p] && p == 0 && l == 0) ? cur[2] : 16'h0000, 16'h0000}
          ^ {32{!sampleStb}};
        instVal[p][l] = (phMask[p] ? cur[3] : 16'h0000) ^ {16{!sampleStb}};
      end
endmodule : dpr_frontend_model
`default_nettype wire

// File: tb_diff_protection_restraint_logic.sv
// self-checking bench of the restraint block: one task per behaviour
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin errCount++; \
  $display("Error %s expected %h seen %h", n, e, s); end end
module tb_diff_protection_restraint_logic;
  logic clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, rdErr, sampleStb, crossActive;
  logic [7:0] paddr; // register byte address
  logic [31:0] pwdata, prdata, rd; // write data, read data, last read word
  logic [2:0] asymDet, trip, extBlock, harmBlock, unrTrip, phMask; // per-phase flags
  logic signed [15:0] cur [4]; // currents handed to the front-end model
  logic signed [15:0] dcVal [3][2], instVal [3][2]; // dc zero except in the dc doubled check
  dpr_pkg::dpr_phasor_t fundPh [3][2], h2Ph [3][2], hz [3][2]; // hz: odd harmonics, zero until the extra harmonic check
  int errCount = 0, comparisons = 0;
  dpr_restraint #(.NLOC(2), .SPC(8)) dpr_restraint_inst (.clk_sys, .rst_b, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sampleStb, .fundPh, .h2Ph,
    .h3Ph(hz), .h5Ph(hz), .dcVal, .instVal, .asymDet, .trip, .extBlock, .harmBlock,
    .crossActive, .unrTrip);
  dpr_frontend_model #(.NLOC(2)) dpr_frontend_model_inst (.clk_sys, .rst_b, .phMask, .cur,
    .sampleStb, .fundPh, .h2Ph, .instVal);
  // -----------------------------------------
  // bus and stimulus helpers
  // -----------------------------------------
  // one APB transfer, held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++)
      @(posedge clk_sys);
    rd = prdata;
    rdErr = pslverr;
    if (n >= 20)
      errCount++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // new currents land on an edge and stand until changed
  task automatic setIn(input logic [2:0] m, input int a0, a1, h, v);
    @(posedge clk_sys);
    phMask <= m;
    cur <= '{16'(a0), 16'(a1), 16'(h), 16'(v)};
  endtask : setIn
  // let n strobes pass, then look once the flags have settled
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys iff sampleStb === 1'b1);
    @(posedge clk_sys);
    #1;
  endtask : step
  // -----------------------------------------
  // scenarios
  // -----------------------------------------
  task automatic s_regs();
    logic [31:0] rv [10] = '{32'h01, 32'h100, 32'h40, 32'h1000, 32'h64, 32'h0F, 32'h1E,
      32'h28, 32'h2000, 32'h80};
    for (int i = 0; i < 10; i++)
    begin
      apb(1'b0, 8'(4 * i), 32'h0);
      `CHK("reset value", rv[i], rd)
    end
    apb(1'b0, 8'h2C, 32'h0);
    `CHK("unmapped error", 1'b1, rdErr)
  endtask : s_regs
  // pickup boundary, then an internal fault fed from both ends
  task automatic s_internal();
    setIn(3'b001, 'h80, 'h80, 0, 0);
    step(2);
    `CHK("trip at pickup", 3'b000, trip)
    setIn(3'b001, 'hC0, 'hC0, 0, 0);
    dcVal[0][0] <= 16'h0100;
    step(2);
    `CHK("dc doubled", 3'b000, trip)
    setIn(3'b001, 'h200, 'h200, 0, 0);
    dcVal[0][0] <= 16'h0000;
    step(2);
    `CHK("internal trip", 3'b001, trip)
  endtask : s_internal
  // second harmonic edge, crossblock with its time limit, asymmetry detector
  task automatic s_harm();
    setIn(3'b001, 'h200, 'h200, 'h99, 0);
    step(2);
    `CHK("h2 under", 3'b001, trip)
    setIn(3'b001, 'h200, 'h200, 'h9A, 0);
    step(2);
    `CHK("h2 flag", 3'b001, harmBlock)
    `CHK("h2 trip", 3'b000, trip)
    setIn(3'b111, 'h200, 'h200, 0, 0);
    apb(1'b1, 8'h1C, 32'h2);
    apb(1'b1, 8'h00, 32'h5);
    setIn(3'b111, 'h200, 'h200, 'h9A, 0);
    step(1);
    `CHK("cross on", 1'b1, crossActive)
    `CHK("cross trip", 3'b000, trip)
    step(4);
    `CHK("cross limit", 3'b110, trip)
    apb(1'b1, 8'h00, 32'h21);
    setIn(3'b111, 'h200, 'h200, 0, 0);
    asymDet <= 3'b010;
    step(2);
    `CHK("asym trip", 3'b101, trip)
    apb(1'b1, 8'h00, 32'h9);
    hz[0][0].re <= 16'h0200;
    step(2);
    `CHK("extra harmonic", 3'b001, harmBlock)
  endtask : s_harm
  // unrestrained stage on fundamental under heavy harmonics, then on samples
  task automatic s_unr();
    apb(1'b1, 8'h00, 32'h1);
    setIn(3'b001, 'h1100, 'h1100, 'h1000, 0);
    asymDet <= 3'b000;
    step(2);
    `CHK("unr fund", 3'b001, unrTrip)
    `CHK("unr over harm", 3'b001, trip)
    apb(1'b1, 8'h20, 32'h40);
    setIn(3'b001, 0, 0, 0, 90);
    step(2);
    `CHK("inst under", 3'b000, unrTrip)
    setIn(3'b001, 0, 0, 0, 91);
    step(2);
    `CHK("inst over", 3'b001, unrTrip)
    apb(1'b1, 8'h20, 32'h2000);
  endtask : s_unr
  // through fault with saturation, then a consequential internal fault
  task automatic s_ext();
    setIn(3'b001, 0, 0, 0, 0);
    step(2);
    setIn(3'b001, 'h900, -'h900, 0, 0);
    step(2);
    `CHK("external found", 3'b001, extBlock)
    setIn(3'b001, 'h900, -'h400, 0, 0);
    step(4);
    `CHK("saturated trip", 3'b000, trip)
    `CHK("block held", 3'b001, extBlock)
    apb(1'b1, 8'h00, 32'h3);
    step(1);
    `CHK("block all", 3'b111, extBlock)
    setIn(3'b001, 'h400, 'h400, 0, 0);
    step(10);
    `CHK("block cancelled", 3'b000, extBlock)
    `CHK("consequential trip", 3'b001, trip)
  endtask : s_ext
  // verdict, reached from the main sequence or the watchdog
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // a hang costs one mismatch and still ends in the verdict
  initial
  begin
    #100000;
    errCount++;
    end_sim();
  end
  initial
  begin
    {rst_b, psel, penable, pwrite, paddr, pwdata, asymDet, phMask} = '0;
    cur = '{default: '0};
    dcVal = '{default: '0};
    hz = '{default: '0};
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    s_regs();
    s_internal();
    s_harm();
    s_unr();
    s_ext();
    end_sim();
  end
endmodule : tb_diff_protection_restraint_logic
`default_nettype wire
